// ==== src/dual_timer_defs.vh ====
// constants for the dual timer/counter block
`ifndef DUAL_TIMER_DEFS_VH
`define DUAL_TIMER_DEFS_VH

// ==========================================================
// special function register addresses
`define ADDR_POWER_CONTROL   8'h87
`define ADDR_TIMER_CONTROL   8'h88
`define ADDR_TIMER_MODE      8'h89
`define ADDR_LOW_UNIT_ZERO   8'h8A
`define ADDR_LOW_UNIT_ONE    8'h8B
`define ADDR_HIGH_UNIT_ZERO  8'h8C
`define ADDR_HIGH_UNIT_ONE   8'h8D

// ==========================================================
// timer control register fields
`define TIMER_CONTROL_REGISTER_OVF_ONE         7
`define TIMER_CONTROL_REGISTER_RUN_ONE         6
`define TIMER_CONTROL_REGISTER_OVF_ZERO        5
`define TIMER_CONTROL_REGISTER_RUN_ZERO        4

// ==========================================================
// timer mode register fields, per unit nibble
`define TIMER_MODE_REGISTER_GATE            3
`define TIMER_MODE_REGISTER_CT              2
`define MODE_13BIT           2'h0
`define MODE_16BIT           2'h1
`define MODE_RELOAD          2'h2
`define MODE_SPLIT           2'h3

// ==========================================================
// power control fields
`define POWER_CONTROL_DOUBLE          7
`define POWER_CONTROL_STOP            1
`define POWER_CONTROL_IDLE            0

// ==========================================================
// reset values and timing
`define RESET_BYTE           8'h00
`define MACHINE_CYCLE_CLKS   12
`define PRESCALE_LAST        4'hB

`endif

// ==== src/dual_timer_counter.v ====
// two 16-bit timer/counter units with power control register
`timescale 1ns/1ps
`include "dual_timer_defs.vh"

// Functional notes
// - two independent 16-bit timer/counter units
// - timer advances once per 12 clocks
// - counter advances on count input falling edge
// - edge recognition spans two machine cycles
// - run bits start units, control bits 6,4
// - mode 00 is 13 bits, mode 01 16
// - mode 10 reloads low byte from high
// - unit one mode 11 holds its value
// - unit zero mode 11 splits into bytes
// - stop bit halts timers until external interrupt
// - idle halts flash only, bits 6:2 unused
// - overflow sets flag, software or service clears
// - select bit one counts edges, zero times
// - mode register nibbles: unit one high
// - gate set counts gating edges while running
module dual_timer_counter (
    // clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rst_n,
    // special function register port
    input  wire [7:0] i_sfr_addr,
    input  wire [7:0] i_sfr_wdata,
    input  wire       i_sfr_we,
    input  wire       i_sfr_re,
    output reg  [7:0] o_sfr_rdata,
    // external pins
    input  wire       i_count_input_unit_zero,
    input  wire       i_count_input_unit_one,
    input  wire       i_gate_unit_zero,
    input  wire       i_gate_unit_one,
    // interrupt service and wake events
    input  wire       i_irq_ack_unit_zero,
    input  wire       i_irq_ack_unit_one,
    input  wire       i_ext_irq,
    input  wire       i_int_irq,
    // status outputs
    output wire       o_overflow_flag_unit_zero,
    output wire       o_overflow_flag_unit_one,
    output wire       o_flash_hold,
    output wire       o_periph_stop
);

    // ======================================================
    // registers
    reg [7:0] low_count_byte_unit_zero_reg;
    reg [7:0] high_count_byte_unit_zero_reg;
    reg [7:0] low_count_byte_unit_one_reg;
    reg [7:0] high_count_byte_unit_one_reg;
    reg [7:0] timer_mode_register_reg;
    reg [7:0] timer_control_register_reg;
    reg [7:0] power_control_reg;
    reg [3:0] prescale_reg;

    wire [3:0] pins;
    reg  [3:0] sync1_reg;
    reg  [3:0] sync2_reg;
    reg  [3:0] sync3_reg;
    reg  [3:0] level_reg;
    reg  [3:0] sample_reg;
    wire [3:0] fall;

    wire       mc_tick;
    wire       stop;
    wire [1:0] mode_zero;
    wire [1:0] mode_one;
    wire       split;
    wire       run_bit_unit_zero;
    wire       run_bit_unit_one;
    wire       src_zero;
    wire       src_one;
    wire       evt_zero;
    wire       evt_one;
    wire       evt_high;
    reg [16:0] adv_zero;
    reg [16:0] adv_one;
    reg [7:0]  low_zero_next;
    reg [7:0]  high_zero_next;
    reg        ovf_zero_set;
    reg        ovf_one_set;
    wire       wr_timer_control_register;

    // ======================================================
    // one counting step for modes 00, 01 and 10
    function [16:0] advance;
        input [15:0] v;
        input [1:0]  m;
        reg   [12:0] c13;
        reg   [16:0] r;
        begin
            c13 = {v[15:8], v[4:0]} + 13'h0001;
            r   = {1'b0, v};
            case (m)
                `MODE_13BIT: begin
                    r = {(&{v[15:8], v[4:0]}), c13[12:5],
                         3'h0, c13[4:0]};
                end
                `MODE_16BIT: begin
                    r = {1'b0, v} + 17'h00001;
                end
                `MODE_RELOAD: begin
                    if (&v[7:0]) begin
                        r = {1'b1, v[15:8], v[15:8]};
                    end else begin
                        r = {1'b0, v[15:8], v[7:0] + 8'h01};
                    end
                end
                default: begin
                    r = {1'b0, v};
                end
            endcase
            advance = r;
        end
    endfunction

    // ======================================================
    // machine cycle prescaler, frozen while stopped
    assign stop    = power_control_reg[`POWER_CONTROL_STOP];
    assign mc_tick = (prescale_reg == `PRESCALE_LAST);

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prescale_reg <= 4'h0;
        end else if (stop) begin
            prescale_reg <= prescale_reg;
        end else if (mc_tick) begin
            prescale_reg <= 4'h0;
        end else begin
            prescale_reg <= prescale_reg + 4'h1;
        end
    end

    // ======================================================
    // pin synchronisers and per-machine-cycle edge sampling
    assign pins = {i_gate_unit_one, i_gate_unit_zero,
                   i_count_input_unit_one, i_count_input_unit_zero};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            always @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync1_reg[gi]  <= 1'b1;
                    sync2_reg[gi]  <= 1'b1;
                    sync3_reg[gi]  <= 1'b1;
                    level_reg[gi]  <= 1'b1;
                    sample_reg[gi] <= 1'b1;
                end else begin
                    sync1_reg[gi] <= pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    // a change counts only once two stages agree
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        level_reg[gi] <= sync3_reg[gi];
                    end
                    // sampled once a machine cycle, so a level
                    // held shorter than that may be missed
                    if (mc_tick) begin
                        sample_reg[gi] <= level_reg[gi];
                    end
                end
            end
            // high in one sample, low in the next: two cycles
            assign fall[gi] = mc_tick & sample_reg[gi]
                              & ~level_reg[gi];
        end
    endgenerate

    // ======================================================
    // count event selection per unit
    assign mode_zero = timer_mode_register_reg[1:0];
    assign mode_one  = timer_mode_register_reg[5:4];
    assign split     = (mode_zero == `MODE_SPLIT);
    assign run_bit_unit_zero =
        timer_control_register_reg[`TIMER_CONTROL_REGISTER_RUN_ZERO];
    assign run_bit_unit_one =
        timer_control_register_reg[`TIMER_CONTROL_REGISTER_RUN_ONE];

    // gate set: gating edges; else select bit picks source
    assign src_zero =
        timer_mode_register_reg[`TIMER_MODE_REGISTER_GATE] ? fall[2] :
        timer_mode_register_reg[`TIMER_MODE_REGISTER_CT]   ? fall[0] :
        mc_tick;
    assign src_one =
        timer_mode_register_reg[4 + `TIMER_MODE_REGISTER_GATE] ? fall[3] :
        timer_mode_register_reg[4 + `TIMER_MODE_REGISTER_CT]   ? fall[1] :
        mc_tick;

    // run bits start the units; stop freezes both
    assign evt_zero = ~stop & run_bit_unit_zero & src_zero;
    // in split mode unit one loses its run bit to the high byte
    assign evt_one  = ~stop & (mode_one != `MODE_SPLIT)
                      & (split | run_bit_unit_one) & src_one;
    assign evt_high = ~stop & split & run_bit_unit_one
                      & mc_tick;

    // ======================================================
    // next count values and overflow events
    always @* begin
        adv_zero = advance({high_count_byte_unit_zero_reg,
                            low_count_byte_unit_zero_reg}, mode_zero);
        adv_one  = advance({high_count_byte_unit_one_reg,
                            low_count_byte_unit_one_reg}, mode_one);
        low_zero_next  = low_count_byte_unit_zero_reg;
        high_zero_next = high_count_byte_unit_zero_reg;
        ovf_zero_set   = 1'b0;
        ovf_one_set    = 1'b0;
        if (split) begin
            // two independent 8-bit counters
            if (evt_zero) begin
                low_zero_next = low_count_byte_unit_zero_reg + 8'h01;
                ovf_zero_set  = &low_count_byte_unit_zero_reg;
            end
            if (evt_high) begin
                high_zero_next = high_count_byte_unit_zero_reg + 8'h01;
                ovf_one_set    = &high_count_byte_unit_zero_reg;
            end
        end else if (evt_zero) begin
            low_zero_next  = adv_zero[7:0];
            high_zero_next = adv_zero[15:8];
            ovf_zero_set   = adv_zero[16];
        end
        if (!split && evt_one) begin
            ovf_one_set = adv_one[16];
        end
    end

    // ======================================================
    // register writes and counting
    assign wr_timer_control_register = i_sfr_we & (i_sfr_addr == `ADDR_TIMER_CONTROL);

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_count_byte_unit_zero_reg  <= `RESET_BYTE;
            high_count_byte_unit_zero_reg <= `RESET_BYTE;
            low_count_byte_unit_one_reg   <= `RESET_BYTE;
            high_count_byte_unit_one_reg  <= `RESET_BYTE;
            timer_mode_register_reg       <= `RESET_BYTE;
            timer_control_register_reg    <= `RESET_BYTE;
            power_control_reg             <= `RESET_BYTE;
        end else begin
            // software write wins over a count in the same cycle
            if (i_sfr_we && i_sfr_addr == `ADDR_LOW_UNIT_ZERO) begin
                low_count_byte_unit_zero_reg <= i_sfr_wdata;
            end else begin
                low_count_byte_unit_zero_reg <= low_zero_next;
            end
            if (i_sfr_we && i_sfr_addr == `ADDR_HIGH_UNIT_ZERO) begin
                high_count_byte_unit_zero_reg <= i_sfr_wdata;
            end else begin
                high_count_byte_unit_zero_reg <= high_zero_next;
            end
            if (i_sfr_we && i_sfr_addr == `ADDR_LOW_UNIT_ONE) begin
                low_count_byte_unit_one_reg <= i_sfr_wdata;
            end else if (evt_one) begin
                low_count_byte_unit_one_reg <= adv_one[7:0];
            end
            if (i_sfr_we && i_sfr_addr == `ADDR_HIGH_UNIT_ONE) begin
                high_count_byte_unit_one_reg <= i_sfr_wdata;
            end else if (evt_one) begin
                high_count_byte_unit_one_reg <= adv_one[15:8];
            end
            if (i_sfr_we && i_sfr_addr == `ADDR_TIMER_MODE) begin
                timer_mode_register_reg <= i_sfr_wdata;
            end

            // control byte; flags: hardware set beats any clear
            if (wr_timer_control_register) begin
                timer_control_register_reg <= i_sfr_wdata;
            end
            if (ovf_one_set) begin
                timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ONE] <= 1'b1;
            end else if (wr_timer_control_register) begin
                timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ONE] <=
                    i_sfr_wdata[`TIMER_CONTROL_REGISTER_OVF_ONE];
            end else if (i_irq_ack_unit_one) begin
                timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ONE] <= 1'b0;
            end
            if (ovf_zero_set) begin
                timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ZERO] <= 1'b1;
            end else if (wr_timer_control_register) begin
                timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ZERO] <=
                    i_sfr_wdata[`TIMER_CONTROL_REGISTER_OVF_ZERO];
            end else if (i_irq_ack_unit_zero) begin
                timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ZERO] <= 1'b0;
            end

            // power control; unused bits never store
            if (i_sfr_we && i_sfr_addr == `ADDR_POWER_CONTROL) begin
                power_control_reg <= {i_sfr_wdata[`POWER_CONTROL_DOUBLE],
                                      5'h00, i_sfr_wdata[1:0]};
            end else begin
                if (i_ext_irq) begin
                    power_control_reg[`POWER_CONTROL_STOP] <= 1'b0;
                end
                if (i_int_irq) begin
                    power_control_reg[`POWER_CONTROL_IDLE] <= 1'b0;
                end
            end
        end
    end

    // ======================================================
    // registered read port, one cycle after the strobe
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_re) begin
            case (i_sfr_addr)
                `ADDR_POWER_CONTROL:  o_sfr_rdata <= power_control_reg;
                `ADDR_TIMER_CONTROL:
                    o_sfr_rdata <= timer_control_register_reg;
                `ADDR_TIMER_MODE:
                    o_sfr_rdata <= timer_mode_register_reg;
                `ADDR_LOW_UNIT_ZERO:
                    o_sfr_rdata <= low_count_byte_unit_zero_reg;
                `ADDR_HIGH_UNIT_ZERO:
                    o_sfr_rdata <= high_count_byte_unit_zero_reg;
                `ADDR_LOW_UNIT_ONE:
                    o_sfr_rdata <= low_count_byte_unit_one_reg;
                `ADDR_HIGH_UNIT_ONE:
                    o_sfr_rdata <= high_count_byte_unit_one_reg;
                default:              o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ======================================================
    // status outputs; unit zero reload with unit one in 13/16
    // bit mode is left to software
    assign o_overflow_flag_unit_zero =
        timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ZERO];
    assign o_overflow_flag_unit_one =
        timer_control_register_reg[`TIMER_CONTROL_REGISTER_OVF_ONE];
    assign o_flash_hold  = power_control_reg[`POWER_CONTROL_STOP]
                           | power_control_reg[`POWER_CONTROL_IDLE];
    assign o_periph_stop = power_control_reg[`POWER_CONTROL_STOP];

endmodule // dual_timer_counter

// ==== testbench/dual_timer_counter_props.sv ====
// concurrent checks on the dual timer/counter ports
`timescale 1ns/1ps
module dual_timer_counter_props (
    // clock and reset
    input wire       i_clk_sys,
    input wire       i_rst_n,
    // register port
    input wire [7:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire       i_sfr_we,
    input wire       i_sfr_re,
    input wire [7:0] o_sfr_rdata,
    // events and status
    input wire       i_irq_ack_unit_zero,
    input wire       i_ext_irq,
    input wire       i_int_irq,
    input wire       o_overflow_flag_unit_zero,
    input wire       o_flash_hold,
    input wire       o_periph_stop
);
    // ==========================================================
    // helpers
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire pw = i_sfr_we && (i_sfr_addr == 8'h87);
    wire cw = i_sfr_we && (i_sfr_addr == 8'h88);
    wire f0 = o_overflow_flag_unit_zero;
    // ==========================================================
    // properties
    property p_stop_set;
        pw && i_sfr_wdata[1] |=> o_periph_stop && o_flash_hold;
    endproperty
    a_stop_set: assert property (p_stop_set)
        else $error("stop not set");
    property p_stop_keep;
        o_periph_stop && !i_ext_irq && !pw |=> o_periph_stop;
    endproperty
    a_stop_keep: assert property (p_stop_keep)
        else $error("stop lost");
    property p_wake;
        o_periph_stop && i_ext_irq && !pw |=> !o_periph_stop;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake");
    property p_frozen;
        o_periph_stop && !cw && !i_irq_ack_unit_zero |=> $stable(f0);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("flag moved");
    property p_idle_set;
        pw && i_sfr_wdata[0] |=> o_flash_hold;
    endproperty
    a_idle_set: assert property (p_idle_set)
        else $error("idle not set");
    property p_idle_wake;
        !pw && i_int_irq && !o_periph_stop |=> !o_flash_hold;
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("idle kept");
    property p_power_control_rd;
        i_sfr_re && i_sfr_addr == 8'h87 |=> o_sfr_rdata[6:2] == 5'h00;
    endproperty
    a_power_control_rd: assert property (p_power_control_rd)
        else $error("unused bits");
    property p_ack;
        o_periph_stop && i_irq_ack_unit_zero && !cw |=> !f0;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack ignored");
    property p_flag_wr;
        o_periph_stop && cw |=> f0 == $past(i_sfr_wdata[5]);
    endproperty
    a_flag_wr: assert property (p_flag_wr)
        else $error("flag write");
    property p_rd_hold;
        !i_sfr_re |=> $stable(o_sfr_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("rdata moved");
    // ==========================================================
    // coverage
    c_wake: cover property (o_periph_stop ##1 !o_periph_stop);
    c_flag: cover property ($rose(f0));
    c_idle: cover property (o_flash_hold && !o_periph_stop);
endmodule // dual_timer_counter_props

bind dual_timer_counter dual_timer_counter_props i_props (
    .i_clk_sys                 (i_clk_sys),
    .i_rst_n                   (i_rst_n),
    .i_sfr_addr                (i_sfr_addr),
    .i_sfr_wdata               (i_sfr_wdata),
    .i_sfr_we                  (i_sfr_we),
    .i_sfr_re                  (i_sfr_re),
    .o_sfr_rdata               (o_sfr_rdata),
    .i_irq_ack_unit_zero       (i_irq_ack_unit_zero),
    .i_ext_irq                 (i_ext_irq),
    .i_int_irq                 (i_int_irq),
    .o_overflow_flag_unit_zero (o_overflow_flag_unit_zero),
    .o_flash_hold              (o_flash_hold),
    .o_periph_stop             (o_periph_stop)
);

// ==== testbench/pin_source.sv ====
// count and gate pin source for the dual timer bench
`timescale 1ns/1ps
module pin_source (
    // clock
    input  wire       i_clk_sys,
    // pins: count zero, count one, gate zero, gate one
    output reg  [3:0] o_pins
);
    // idle high, matching the preset synchronisers
    initial o_pins = 4'hF;
    // levels are held well over one machine cycle
    task pulse(input int sel, input int n, input int hold);
        repeat (n) begin
            @(negedge i_clk_sys);
            o_pins[sel] = 1'b0;
            repeat (hold) @(negedge i_clk_sys);
            o_pins[sel] = 1'b1;
            repeat (hold) @(negedge i_clk_sys);
        end
    endtask
endmodule // pin_source

// ==== testbench/dual_timer_counter_tb_top.sv ====
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_tb_top;
    reg        clk;
    reg        rst_n;
    reg  [7:0] addr;
    reg  [7:0] wdata;
    reg        we;
    reg        re;
    reg  [3:0] irq;
    wire [7:0] rdata;
    wire [3:0] pins;
    wire       flag0;
    wire       flag1;
    wire       hold;
    wire       stop;
    int        n_fail;
    int        n_checks;
    int        cycles;
    // ==========================================================
    // instances
    dual_timer_counter i_dut (
        .i_clk_sys                 (clk),
        .i_rst_n                   (rst_n),
        .i_sfr_addr                (addr),
        .i_sfr_wdata               (wdata),
        .i_sfr_we                  (we),
        .i_sfr_re                  (re),
        .o_sfr_rdata               (rdata),
        .i_count_input_unit_zero   (pins[0]),
        .i_count_input_unit_one    (pins[1]),
        .i_gate_unit_zero          (pins[2]),
        .i_gate_unit_one           (pins[3]),
        .i_irq_ack_unit_zero       (irq[0]),
        .i_irq_ack_unit_one        (irq[3]),
        .i_ext_irq                 (irq[1]),
        .i_int_irq                 (irq[2]),
        .o_overflow_flag_unit_zero (flag0),
        .o_overflow_flag_unit_one  (flag1),
        .o_flash_hold              (hold),
        .o_periph_stop             (stop)
    );
    pin_source i_src (.i_clk_sys(clk), .o_pins(pins));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // a hang ends in the closing report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    // ==========================================================
    // shared tasks
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        chk(rdata, exp);
    endtask
    task strobe(input logic [3:0] m);
        @(negedge clk);
        irq = m;
        @(negedge clk);
        irq = 4'h0;
    endtask
    task wait_f0;
        int i;
        i = 0;
        while (flag0 !== 1'b1 && i < 500) begin
            @(negedge clk);
            i++;
        end
        chk({7'h00, flag0}, 8'h01);
    endtask
    // ==========================================================
    // scenarios
    task t_reset;
        int a;
        for (a = 8'h86; a <= 8'h8E; a++) begin
            rd(a[7:0], 8'h00);
        end
        chk({4'h0, flag0, flag1, hold, stop}, 8'h00);
        $display("reset values done");
    endtask
    task t_timer;
        wr(8'h89, 8'h01);
        wr(8'h8C, 8'hFF);
        wr(8'h8A, 8'hFD);
        wr(8'h88, 8'h10);
        wait_f0();
        // reads land 115 clocks after the wrap: nine ticks
        repeat (113) @(negedge clk);
        rd(8'h8A, 8'h09);
        rd(8'h8C, 8'h00);
        strobe(4'h1);
        chk({7'h00, flag0}, 8'h00);
        wr(8'h88, 8'h00);
        $display("timer rate done");
    endtask
    task t_wrap(input logic [7:0] m, th, tl, e);
        wr(8'h89, m);
        wr(8'h8C, th);
        wr(8'h8A, tl);
        wr(8'h88, 8'h10);
        wait_f0();
        rd(8'h8A, e);
        wr(8'h88, 8'h00);
        $display("wrap mode done");
    endtask
    task t_hold1;
        wr(8'h89, 8'h30);
        wr(8'h8B, 8'h5A);
        wr(8'h88, 8'h40);
        repeat (60) @(negedge clk);
        rd(8'h8B, 8'h5A);
        wr(8'h88, 8'h00);
        $display("unit one hold done");
    endtask
    task t_count;
        wr(8'h89, 8'h50);
        wr(8'h8B, 8'h00);
        wr(8'h88, 8'h40);
        i_src.pulse(1, 3, 24);
        repeat (48) @(negedge clk);
        rd(8'h8B, 8'h03);
        wr(8'h89, 8'h08);
        wr(8'h8A, 8'h00);
        wr(8'h88, 8'h10);
        i_src.pulse(2, 2, 24);
        repeat (48) @(negedge clk);
        rd(8'h8A, 8'h02);
        wr(8'h88, 8'h00);
        i_src.pulse(2, 1, 24);
        repeat (48) @(negedge clk);
        rd(8'h8A, 8'h02);
        $display("event count done");
    endtask
    task t_power;
        wr(8'h89, 8'h01);
        wr(8'h87, 8'hFF);
        chk({6'h00, stop, hold}, 8'h03);
        rd(8'h87, 8'h83);
        wr(8'h8A, 8'h40);
        wr(8'h88, 8'h30);
        repeat (60) @(negedge clk);
        rd(8'h8A, 8'h40);
        chk({7'h00, flag0}, 8'h01);
        strobe(4'h1);
        chk({7'h00, flag0}, 8'h00);
        strobe(4'h2);
        chk({6'h00, stop, hold}, 8'h01);
        strobe(4'h4);
        chk({6'h00, stop, hold}, 8'h00);
        wr(8'h88, 8'h00);
        $display("power control done");
    endtask
    // low byte wraps one tick before the high byte
    task t_split;
        wr(8'h89, 8'h03);
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'hFD);
        wr(8'h88, 8'h50);
        wait_f0();
        chk({7'h00, flag1}, 8'h00);
        repeat (12) @(negedge clk);
        chk({7'h00, flag1}, 8'h01);
        rd(8'h8A, 8'h01);
        strobe(4'h8);
        chk({7'h00, flag1}, 8'h00);
        wr(8'h88, 8'h00);
        $display("split mode done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        we = 1'b0;
        re = 1'b0;
        irq = 4'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_timer();
        t_wrap(8'h00, 8'hFF, 8'h1E, 8'h00);
        t_wrap(8'h22, 8'hF0, 8'hFE, 8'hF0);
        t_hold1();
        t_count();
        t_power();
        t_split();
        stop_test();
    end
endmodule // dual_timer_counter_tb_top
